/* File: bench/fcq_flash_model.sv */
/*
 * fcq_flash_model: behavioural flash device for the host controller bench,
 * query mode, reset command, accelerated bypass programming, reset pin.
 * Assumes it sees the controller's registered pins and drives fl_dq_i.
 */
`timescale 1ns/1ps
module fcq_flash_model #(
    // stand-in for every autoselect read; the value is arbitrary
    parameter logic [15:0] ASEL_WORD = 16'h0a5a
) (
    // flash pins from the controller
    input wire fcq_pkg::fcq_pins_type pins,
    // data pin level back to the controller
    output logic [15:0] fl_dq_i
);
    import fcq_pkg::*;
    logic query_ff = 1'b0;
    logic bypass_ff = 1'b0;
    logic asel_ff = 1'b0;
    logic from_asel_ff = 1'b0;
    logic [15:0] last_ff = 16'h0000;
    logic [15:0] mem_ff [logic [21:0]];
    logic [21:0] qa;
    logic [15:0] rd;
    logic drive;
    // query table; every other place reads zero
    function automatic logic [15:0] qval(input logic [21:0] a);
        case (a)
            22'h10: return 16'h0051;
            22'h11: return 16'h0052;
            22'h12: return 16'h0059;
            22'h13: return 16'h0002;
            22'h15: return 16'h0040;
            22'h1b: return 16'h0027;
            22'h1c: return 16'h0036;
            22'h1f: return 16'h0004;
            22'h21: return 16'h000a;
            22'h23: return 16'h0005;
            22'h25: return 16'h0004;
            default: return 16'h0000;
        endcase
    endfunction
    // byte addresses are twice the word address
    assign qa = pins.byte_n ? pins.addr : (pins.addr >> 1);
    assign drive = !pins.ce_n && !pins.oe_n && pins.reset_n;
    // array places never programmed read the inverted address
    always @* begin
        if (query_ff) begin
            rd = qval(qa);
        end else if (asel_ff) begin
            rd = ASEL_WORD;
        end else if (mem_ff.exists(pins.addr)) begin
            rd = mem_ff[pins.addr];
        end else begin
            rd = ~pins.addr[15:0];
        end
    end
    // a released bus shows the inverse of the last value, so stale reads fail
    assign fl_dq_i = drive ? rd : ~last_ff;
    always @(posedge pins.oe_n) begin
        last_ff = rd;
    end
    // commands are captured on the rising write strobe
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.reset_n) begin
            if (pins.dq_o[7:0] == 8'h98 && qa == CFI_ADDR_WORD) begin
                query_ff = 1'b1;
                from_asel_ff = asel_ff;
            end else if (pins.dq_o[7:0] == 8'hf0) begin
                // a query entered from autoselect falls back to autoselect
                asel_ff = query_ff && from_asel_ff;
                query_ff = 1'b0;
                bypass_ff = 1'b0;
            end else if (bypass_ff && pins.acc_boost) begin
                mem_ff[pins.addr] = pins.dq_o;
                bypass_ff = 1'b0;
            end else if (pins.dq_o[7:0] == 8'ha0 && pins.acc_boost) begin
                bypass_ff = 1'b1;
            end else if (pins.dq_o[7:0] == 8'h90) begin
                // unlock cycles are not modelled; one 90h write enters autoselect
                asel_ff = 1'b1;
            end
        end
    end
    // a reset pulse drops query mode and any half-done sequence
    always @(negedge pins.reset_n) begin
        query_ff = 1'b0;
        bypass_ff = 1'b0;
        asel_ff = 1'b0;
        from_asel_ff = 1'b0;
    end
endmodule

/* File: bench/tb.sv */
/*
 * tb: self-checking bench for fcq_host against the behavioural flash model.
 * Assumes the hand-over timing of the user command port; 20 MHz clock.
 */
`timescale 1ns/1ps
module tb;
    import fcq_pkg::*;
    // query words 10h..26h
    localparam logic [15:0] QTAB [23] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000,
        16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036,
        16'h0000, 16'h0000, 16'h0004, 16'h0000, 16'h000a, 16'h0000, 16'h0005, 16'h0000,
        16'h0004, 16'h0000};
    // what the model returns for any autoselect read; arbitrary
    localparam logic [15:0] ASEL_WORD = 16'h0a5a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    fcq_cmd_type cmd = '0;
    logic cmd_ready, rsp_valid, rsp_err, cfi_mode, got_err;
    logic [15:0] rsp_data, fl_dq_i, got;
    fcq_pins_type pins;
    int n_errors = 0;
    int n_compared = 0;
    always #25 clk = ~clk;
    fcq_host fcq_host_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_data(rsp_data), .cfi_mode(cfi_mode), .pins(pins), .fl_dq_i(fl_dq_i));
    fcq_flash_model #(.ASEL_WORD(ASEL_WORD)) fcq_flash_model_inst (.pins(pins),
        .fl_dq_i(fl_dq_i));
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask
    // one command: held until taken, then wait a bounded time for the answer
    task automatic run(input fcq_op_type op, input logic bm, input logic [21:0] a,
        input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1 cmd_valid = 1'b1;
        cmd = '{op, bm, a, d};
        // cmd_ready seen just after an edge is what the next edge samples
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        check("rsp_valid", 16'h1, {15'h0, rsp_valid});
        got = rsp_data;
        got_err = rsp_err;
    endtask
    task automatic t_reset();
        repeat (10) @(posedge clk);
        #1 check("reset_n in reset", 16'h0, {15'h0, pins.reset_n});
        check("cmd_ready in reset", 16'h0, {15'h0, cmd_ready});
        rst_n = 1'b1;
        repeat (14) @(posedge clk);
        #1 check("cmd_ready", 16'h1, {15'h0, cmd_ready});
        check("reset_n", 16'h1, {15'h0, pins.reset_n});
    endtask
    // reads the whole identification and interface table, then leaves
    task automatic t_query(input logic bm);
        run(OP_CFI_ENTER, bm, bm ? CFI_ADDR_BYTE : CFI_ADDR_WORD, CMD_CFI_QUERY);
        check("cfi_mode", 16'h1, {15'h0, cfi_mode});
        for (int i = 0; i < 23; i++) begin
            run(OP_READ, bm, bm ? 22'(2 * (16 + i)) : 22'(16 + i), 16'h0000);
            check("query word", QTAB[i], got);
        end
        if (!bm) begin
            run(OP_READ, 1'b0, 22'h3fff91, 16'h0000);
            check("masked query", 16'h0052, got);
            check("upper addr", 16'h0, {1'b0, pins.addr[21:7]});
            run(OP_READ, 1'b0, 22'h00003f, 16'h0000);
            check("unmapped", 16'h0000, got);
        end
        run(OP_CFI_EXIT, bm, 22'h000000, CMD_RESET);
        check("cfi_mode exit", 16'h0, {15'h0, cfi_mode});
        run(OP_READ, 1'b0, 22'h000100, 16'h0000);
        check("array after exit", 16'hfeff, got);
    endtask
    task automatic t_accel();
        run(OP_CFI_ENTER, 1'b0, CFI_ADDR_WORD, CMD_CFI_QUERY);
        run(OP_ACC_PROG, 1'b0, 22'h001234, 16'h5a5a);
        check("refused err", 16'h1, {15'h0, got_err});
        check("boost refused", 16'h0, {15'h0, pins.acc_boost});
        run(OP_CFI_EXIT, 1'b0, 22'h000000, CMD_RESET);
        run(OP_ACC_PROG, 1'b0, 22'h001234, 16'h5a5a);
        check("prog err", 16'h0, {15'h0, got_err});
        check("boost on", 16'h1, {15'h0, pins.acc_boost});
        run(OP_ACC_PROG, 1'b0, 22'h001236, 16'ha5a5);
        check("prog err boosted", 16'h0, {15'h0, got_err});
        run(OP_READ, 1'b0, 22'h001234, 16'h0000);
        check("read under boost err", 16'h1, {15'h0, got_err});
        run(OP_ACC_END, 1'b0, 22'h000000, 16'h0000);
        check("boost off", 16'h0, {15'h0, pins.acc_boost});
        run(OP_READ, 1'b0, 22'h001234, 16'h0000);
        check("programmed", 16'h5a5a, got);
        run(OP_READ, 1'b0, 22'h001236, 16'h0000);
        check("programmed boosted", 16'ha5a5, got);
    endtask
    // query entered from autoselect falls back to autoselect on reset command
    task automatic t_asel();
        run(OP_WRITE, 1'b0, 22'h000555, 16'h0090);
        run(OP_CFI_ENTER, 1'b0, CFI_ADDR_WORD, CMD_CFI_QUERY);
        run(OP_READ, 1'b0, 22'h000010, 16'h0000);
        check("query from autoselect", 16'h0051, got);
        run(OP_CFI_EXIT, 1'b0, 22'h000000, CMD_RESET);
        run(OP_READ, 1'b0, 22'h000100, 16'h0000);
        check("back to autoselect", ASEL_WORD, got);
        run(OP_CFI_EXIT, 1'b0, 22'h000000, CMD_RESET);
        run(OP_READ, 1'b0, 22'h000100, 16'h0000);
        check("array after autoselect", 16'hfeff, got);
    endtask
    // every protect level and identify voltage combination
    task automatic t_pins();
        for (int d = 0; d < 4; d++) begin
            run(OP_PIN_SET, 1'b0, 22'h000000, 16'(d));
            check("wp_level", 16'(d & 1), {15'h0, pins.wp_level});
            check("reset_vid", 16'(d >> 1), {15'h0, pins.reset_vid});
        end
        run(OP_PIN_SET, 1'b0, 22'h000000, 16'h0001);
    endtask
    task automatic t_hwreset();
        run(OP_CFI_ENTER, 1'b0, CFI_ADDR_WORD, CMD_CFI_QUERY);
        run(OP_HW_RESET, 1'b0, 22'h000000, 16'h0000);
        check("cfi_mode reset", 16'h0, {15'h0, cfi_mode});
        check("reset_n back", 16'h1, {15'h0, pins.reset_n});
        run(OP_READ, 1'b0, 22'h000777, 16'h0000);
        check("array after reset", 16'hf888, got);
    endtask
    // watchdog: the whole run needs well under 5000 cycles
    initial begin
        #250000;
        n_errors++;
        $display("ERROR watchdog expected done seen timeout");
        complete_run();
    end
    initial begin
        t_reset();
        t_query(1'b0);
        t_query(1'b1);
        t_accel();
        t_asel();
        t_pins();
        t_hwreset();
        complete_run();
    end
endmodule

/* File: common/fcq_pkg.sv */
/*
 * fcq_pkg: constants, operation codes and carrier structs for the host-side
 * controller of a parallel NOR flash with protect/accelerate pin and query mode.
 * Assumes a 20 MHz controller clock and an asynchronous flash bus.
 */
package fcq_pkg;
    localparam int CLK_PERIOD_NS = 50;
    // bus timing in ns; counts round up to whole cycles
    localparam int T_ACCESS_NS = 70;
    localparam int T_WE_PULSE_NS = 35;
    localparam int T_RESET_PULSE_NS = 500;
    localparam int T_BOOST_RAMP_NS = 250;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] RD_CYC =
        8'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
    localparam logic [7:0] WR_CYC = 8'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESET_CYC =
        8'((T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RAMP_CYC = 8'((T_BOOST_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // flash commands and fixed addresses
    localparam logic [15:0] CMD_CFI_QUERY = 16'h0098;
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_BYPASS_PROG = 16'h00a0;
    localparam logic [21:0] CFI_ADDR_WORD = 22'h000055;
    localparam logic [21:0] CFI_ADDR_BYTE = 22'h0000aa;
    localparam logic [21:0] CFI_WORD_MASK = 22'h00007f;
    localparam logic [21:0] BYPASS_ADDR = 22'h000000;
    // pin_set data field positions
    localparam int PIN_WP_BIT = 0;
    localparam int PIN_VID_BIT = 1;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_CFI_ENTER = 3'h2,
        OP_CFI_EXIT = 3'h3,
        OP_ACC_PROG = 3'h4,
        OP_ACC_END = 3'h5,
        OP_HW_RESET = 3'h6,
        OP_PIN_SET = 3'h7
    } fcq_op_type;

    typedef struct packed {
        fcq_op_type op;
        logic byte_mode;
        logic [21:0] addr;
        logic [15:0] data;
    } fcq_cmd_type;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dq_o;
        logic dq_oe_n;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic byte_n;
        logic reset_n;
        logic reset_vid;
        logic wp_level;
        logic acc_boost;
    } fcq_pins_type;
endpackage

/* File: design/fcq_host.sv */
/*
 * fcq_host: host controller that drives a parallel NOR flash through its pins:
 * read/write bus cycles, query mode entry and exit, accelerated programming
 * with the boost voltage, temporary unprotect and hardware reset pulses.
 * Assumes external level shifters turn acc_boost and reset_vid into the high
 * voltages, and that fl_dq_i is the asynchronous data pin level.
 */
`timescale 1ns/1ps

module fcq_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // user command port
    input wire logic cmd_valid,
    input wire fcq_pkg::fcq_cmd_type cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [15:0] rsp_data,
    output logic cfi_mode,
    // flash pins
    output fcq_pkg::fcq_pins_type pins,
    input wire logic [15:0] fl_dq_i
);
    import fcq_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b011,
        ST_HOLD = 3'b010,
        ST_RAMP = 3'b110,
        ST_RPULSE = 3'b100
    } fcq_state_type;

    typedef struct packed {
        fcq_state_type st;
        fcq_op_type op;
        logic [7:0] cnt;
        logic rd;
        logic second;
        logic [21:0] a2;
        logic [15:0] d2;
        logic byte_mode;
        logic cfi;
        logic rdy;
        logic rsp_valid;
        logic rsp_err;
        logic [15:0] rsp_data;
        logic [15:0] s1;
        logic [15:0] s2;
        fcq_pins_type pins;
    } fcq_core_type;

    fcq_core_type r_ff;
    fcq_core_type nxt_r;

    // open a bus cycle: address and chip enable first, strobe one cycle later
    function automatic fcq_core_type bus_start(fcq_core_type c, logic rd, logic [21:0] a,
                                               logic [15:0] d);
        fcq_core_type o;
        o = c;
        o.st = ST_SETUP;
        o.rd = rd;
        o.pins.addr = a;
        o.pins.dq_o = d;
        o.pins.dq_oe_n = rd;
        o.pins.ce_n = 1'b0;
        return o;
    endfunction

    // next-state logic for the whole controller
    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = fl_dq_i;
        nxt_r.s2 = r_ff.s1;
        nxt_r.rsp_valid = 1'b0;
        case (r_ff.st)
            ST_IDLE: begin
                nxt_r.rdy = 1'b1;
                if (cmd_valid && r_ff.rdy) begin
                    nxt_r.rdy = 1'b0;
                    nxt_r.op = cmd.op;
                    nxt_r.rsp_err = 1'b0;
                    nxt_r.byte_mode = cmd.byte_mode;
                    nxt_r.pins.byte_n = ~cmd.byte_mode;
                    nxt_r.second = 1'b0;
                    case (cmd.op)
                        OP_READ: begin
                            // high query address bits forced low in word mode
                            nxt_r = bus_start(nxt_r, 1'b1, (r_ff.cfi && !cmd.byte_mode) ?
                                (cmd.addr & CFI_WORD_MASK) : cmd.addr, 16'h0000);
                        end
                        OP_WRITE: nxt_r = bus_start(nxt_r, 1'b0, cmd.addr, cmd.data);
                        OP_CFI_ENTER: begin
                            nxt_r = bus_start(nxt_r, 1'b0, cmd.byte_mode ? CFI_ADDR_BYTE :
                                CFI_ADDR_WORD, CMD_CFI_QUERY);
                        end
                        OP_CFI_EXIT: nxt_r = bus_start(nxt_r, 1'b0, cmd.addr, CMD_RESET);
                        OP_ACC_PROG: begin
                            if (r_ff.cfi) begin
                                // boost outside read mode could wedge the device
                                nxt_r.rsp_valid = 1'b1;
                                nxt_r.rsp_err = 1'b1;
                                nxt_r.rdy = 1'b1;
                            end else begin
                                nxt_r.second = 1'b1;
                                nxt_r.a2 = cmd.addr;
                                nxt_r.d2 = cmd.data;
                                if (r_ff.pins.acc_boost) begin
                                    nxt_r = bus_start(nxt_r, 1'b0, BYPASS_ADDR, CMD_BYPASS_PROG);
                                end else begin
                                    nxt_r.pins.acc_boost = 1'b1;
                                    nxt_r.st = ST_RAMP;
                                    nxt_r.cnt = RAMP_CYC;
                                end
                            end
                        end
                        OP_ACC_END: begin
                            nxt_r.pins.acc_boost = 1'b0;
                            nxt_r.st = ST_RAMP;
                            nxt_r.cnt = RAMP_CYC;
                        end
                        OP_HW_RESET: begin
                            nxt_r.pins.reset_n = 1'b0;
                            nxt_r.st = ST_RPULSE;
                            nxt_r.cnt = RESET_CYC;
                        end
                        OP_PIN_SET: begin
                            // protect pin is always driven to a defined level
                            nxt_r.pins.wp_level = cmd.data[PIN_WP_BIT];
                            nxt_r.pins.reset_vid = cmd.data[PIN_VID_BIT];
                            nxt_r.rsp_valid = 1'b1;
                            nxt_r.rdy = 1'b1;
                        end
                        default: nxt_r.rdy = 1'b1;
                    endcase
                    // the boost voltage serves bypass programming only; plain bus
                    // cycles are refused until the boost has been taken off again
                    if (r_ff.pins.acc_boost && cmd.op inside {OP_READ, OP_WRITE,
                        OP_CFI_ENTER, OP_CFI_EXIT}) begin
                        nxt_r.st = ST_IDLE;
                        nxt_r.pins = r_ff.pins;
                        nxt_r.rsp_valid = 1'b1;
                        nxt_r.rsp_err = 1'b1;
                        nxt_r.rdy = 1'b1;
                    end
                end
            end
            ST_SETUP: begin
                nxt_r.st = ST_STROBE;
                nxt_r.cnt = r_ff.rd ? RD_CYC : WR_CYC;
                nxt_r.pins.oe_n = ~r_ff.rd;
                nxt_r.pins.we_n = r_ff.rd;
            end
            ST_STROBE: begin
                nxt_r.cnt = r_ff.cnt - 8'h01;
                if (r_ff.cnt == 8'h01) begin
                    nxt_r.pins.oe_n = 1'b1;
                    nxt_r.pins.we_n = 1'b1;
                    if (r_ff.rd) begin
                        nxt_r.rsp_data = r_ff.s2;
                    end
                    nxt_r.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                nxt_r.pins.ce_n = 1'b1;
                nxt_r.pins.dq_oe_n = 1'b1;
                if (r_ff.second && r_ff.pins.dq_o == CMD_BYPASS_PROG) begin
                    // second half of the bypass program pair
                    nxt_r.second = 1'b0;
                    nxt_r = bus_start(nxt_r, 1'b0, r_ff.a2, r_ff.d2);
                end else begin
                    if (r_ff.op == OP_CFI_ENTER) begin
                        nxt_r.cfi = 1'b1;
                    end
                    if (r_ff.op == OP_CFI_EXIT) begin
                        nxt_r.cfi = 1'b0;
                    end
                    nxt_r.rsp_valid = 1'b1;
                    nxt_r.st = ST_IDLE;
                end
            end
            ST_RAMP: begin
                // slow edges on the high-voltage pin need settling time
                nxt_r.cnt = r_ff.cnt - 8'h01;
                if (r_ff.cnt == 8'h01) begin
                    if (r_ff.second) begin
                        nxt_r = bus_start(nxt_r, 1'b0, BYPASS_ADDR, CMD_BYPASS_PROG);
                    end else begin
                        nxt_r.rsp_valid = 1'b1;
                        nxt_r.st = ST_IDLE;
                    end
                end
            end
            ST_RPULSE: begin
                nxt_r.cnt = r_ff.cnt - 8'h01;
                if (r_ff.cnt == 8'h01) begin
                    nxt_r.pins.reset_n = 1'b1;
                    nxt_r.cfi = 1'b0;
                    nxt_r.rsp_valid = r_ff.op == OP_HW_RESET;
                    nxt_r.st = ST_IDLE;
                end
            end
            default: nxt_r.st = ST_IDLE;
        endcase
    end

    // state register; reset also pulses the flash reset pin for the full time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_ff <= '0;
            r_ff.st <= ST_RPULSE;
            r_ff.cnt <= RESET_CYC;
            r_ff.pins.dq_oe_n <= 1'b1;
            r_ff.pins.ce_n <= 1'b1;
            r_ff.pins.we_n <= 1'b1;
            r_ff.pins.oe_n <= 1'b1;
            r_ff.pins.byte_n <= 1'b1;
            r_ff.pins.wp_level <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign pins = r_ff.pins;
    assign cmd_ready = r_ff.rdy;
    assign rsp_valid = r_ff.rsp_valid;
    assign rsp_err = r_ff.rsp_err;
    assign rsp_data = r_ff.rsp_data;
    assign cfi_mode = r_ff.cfi;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_wr_start(logic [15:0] d);
        $fell(r_ff.pins.we_n) && r_ff.pins.dq_o == d;
    endsequence
    sequence seq_next_wr;
        ##[2:12] $fell(r_ff.pins.we_n);
    endsequence

    AST_CFI_ENTRY_ADDR: assert property (seq_wr_start(CMD_CFI_QUERY) |->
        r_ff.pins.addr == (r_ff.byte_mode ? CFI_ADDR_BYTE : CFI_ADDR_WORD))
        else $error("query command at wrong address");
    AST_CFI_READ_MASK: assert property (
        r_ff.cfi && !r_ff.byte_mode && !r_ff.pins.oe_n |-> r_ff.pins.addr[21:7] == '0)
        else $error("query read with high address bits set");
    AST_CFI_EXIT: assert property (seq_wr_start(CMD_RESET) |-> ##[1:4] !r_ff.cfi)
        else $error("query mode not left after reset command");
    AST_BYPASS_PAIR: assert property (
        seq_wr_start(CMD_BYPASS_PROG) and r_ff.pins.acc_boost |-> seq_next_wr)
        else $error("bypass program not followed by data write");
    AST_BOOST_FROM_READ: assert property ($rose(r_ff.pins.acc_boost) |-> !r_ff.cfi)
        else $error("boost raised outside read mode");
    AST_BOOST_NO_READ: assert property (r_ff.pins.acc_boost |-> r_ff.pins.oe_n)
        else $error("bus read while boost applied");
    AST_RESET_HOLD: assert property ($fell(r_ff.pins.reset_n) |->
        !r_ff.pins.reset_n [*8])
        else $error("reset pulse too short");
    AST_RESET_TRISTATE: assert property (!r_ff.pins.reset_n |->
        r_ff.pins.dq_oe_n && r_ff.pins.ce_n)
        else $error("bus driven during reset pulse");
endmodule
